// file: lnbi2c_defines.svh
// Constants for the supply-controller two-wire target: addresses, fields, offsets, resets
`ifndef LNBI2C_DEFINES_SVH
`define LNBI2C_DEFINES_SVH

// ----------------------------------------------------------------------
// Two-wire target address and bit counts
// ----------------------------------------------------------------------
`define LNBI2C_ADDR_UPPER 5'h02
`define LNBI2C_BITS_PER_BYTE 4'h8
`define LNBI2C_LAST_RD_BIT 4'h7

// ----------------------------------------------------------------------
// Data byte layout: selector field in the top three bits
// ----------------------------------------------------------------------
`define LNBI2C_SEL_MSB 7
`define LNBI2C_SEL_LSB 5
`define LNBI2C_SEL_STATUS 3'h0
`define LNBI2C_SEL_LAST 3'h3
`define LNBI2C_FAULT_W 5

// ----------------------------------------------------------------------
// APB register byte offsets
// ----------------------------------------------------------------------
`define LNBI2C_OFS_STATUS 8'h00
`define LNBI2C_OFS_TONE 8'h04
`define LNBI2C_OFS_CMD 8'h08
`define LNBI2C_OFS_OUTCTRL 8'h0c
`define LNBI2C_OFS_CTRL 8'h10
`define LNBI2C_OFS_LINKSTAT 8'h14
`define LNBI2C_OFS_XFERCNT 8'h18

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define LNBI2C_CTRL_LINK_EN_BIT 0
`define LNBI2C_CTRL_RESET 1'b1
`define LNBI2C_SYSREG_RESET 8'h00

`endif

// file: lnbi2c_pkg.sv
// Types shared by the supply-controller two-wire target
`default_nettype none

package lnbi2c_pkg;

  // ----------------------------------------------------------------------
  // Link sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WR,
    ST_WR_ACK,
    ST_RD,
    ST_RD_ACK
  } lnbi2c_state_t;

  // ----------------------------------------------------------------------
  // Whole state of the top module
  // ----------------------------------------------------------------------
  typedef struct packed {
    lnbi2c_state_t st;
    logic scl_d;
    logic sda_d;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic rw;
    logic cont;
    logic [1:0] ptr;
    logic sda_oe;
    logic [3:0][7:0] sysreg;
    logic link_en;
    logic [31:0] rdata;
    logic [15:0] xfer_cnt;
  } lnbi2c_core_t;

endpackage : lnbi2c_pkg

`default_nettype wire

// file: lnbi2c_sync.sv
// Two-flop synchroniser for levels entering the system clock domain
`default_nettype none

module lnbi2c_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Asynchronous level in, synchronised level out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } lnbi2c_sync_st_t;

  lnbi2c_sync_st_t cur_reg;
  lnbi2c_sync_st_t cur_next;

  // First flop feeds only the second
  always_comb begin
    cur_next = cur_reg;
    cur_next.meta = async_in;
    cur_next.stable = cur_reg.meta;
  end

  // Register stage, constant reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cur_reg <= {RST_VAL, RST_VAL};
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign sync_out = cur_reg.stable;

endmodule : lnbi2c_sync

`default_nettype wire

// file: lnbi2c_top.sv
// Two-wire target with register read-back, strap addressing and supply-good reset
//
// Overview of operation
// - After read address accepted, shift a register byte out, MSB first.
// - Controller acknowledge on ninth clock makes the device send another byte.
// - Missing acknowledge on ninth clock ends the read and frees the data line.
// - Read bytes copy system registers; status low bits carry live fault flags.
// - Supply-good low: ignore all bus traffic and never acknowledge.
// - Supply-good low: hold all four system registers at zero.
// - Supply-good high: interface operative, writable register bits accept writes.
// - Both strap pins low gives target address 0001000.
// - Strap pins set the two low address bits, high pin the upper one.
// - Write direction: top three data bits pick tone, command or control register.
`include "lnbi2c_defines.svh"
`default_nettype none

module lnbi2c_top
  import lnbi2c_pkg::*;
#(
  parameter int APB_AW = 8
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  // Supply monitor and strap pins
  input wire logic SUPPLY_GOOD_IN,
  input wire logic ADDR_SEL_LOW_IN,
  input wire logic ADDR_SEL_HIGH_IN,
  // Live fault flags from the power stage, same clock
  input wire logic [`LNBI2C_FAULT_W-1:0] FAULT_FLAGS_IN,
  // Two-wire bus, open drain data
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  // System register contents to the power stages
  output logic [7:0] TONE_CFG_OUT,
  output logic [7:0] COMMAND_CFG_OUT,
  output logic [7:0] OUTPUT_CTRL_OUT,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [APB_AW-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT
);

  // ----------------------------------------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------------------------------------
  logic rst_n;
  logic scl_s;
  logic sda_s;
  logic pg_s;
  logic sel_hi_s;
  logic sel_lo_s;

  // Reset enters asynchronously, leaves on the clock
  lnbi2c_sync #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
    .clk_in(CLK_IN),
    .rst_n_in(RESETN_IN),
    .async_in(1'b1),
    .sync_out(rst_n)
  );

  // Bus lines reset high so no false start is seen
  lnbi2c_sync #(.W(2), .RST_VAL(2'b11)) u_bus_sync (
    .clk_in(CLK_IN),
    .rst_n_in(rst_n),
    .async_in({SCL_IN, SDA_IN}),
    .sync_out({scl_s, sda_s})
  );

  // Supply-good and straps reset low: interface starts blocked
  lnbi2c_sync #(.W(3), .RST_VAL(3'b000)) u_pin_sync (
    .clk_in(CLK_IN),
    .rst_n_in(rst_n),
    .async_in({SUPPLY_GOOD_IN, ADDR_SEL_HIGH_IN, ADDR_SEL_LOW_IN}),
    .sync_out({pg_s, sel_hi_s, sel_lo_s})
  );

  // ----------------------------------------------------------------------
  // Bus events and decode
  // ----------------------------------------------------------------------
  lnbi2c_core_t cur_reg;
  lnbi2c_core_t cur_next;
  logic [6:0] own_addr;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic active;
  logic apb_setup;
  logic apb_access;
  logic apb_mapped;
  logic [2:0] wr_sel;

  assign own_addr = {`LNBI2C_ADDR_UPPER, sel_hi_s, sel_lo_s};
  assign scl_rise = scl_s && !cur_reg.scl_d;
  assign scl_fall = !scl_s && cur_reg.scl_d;
  assign start_cond = scl_s && cur_reg.scl_d && cur_reg.sda_d && !sda_s;
  assign stop_cond = scl_s && cur_reg.scl_d && !cur_reg.sda_d && sda_s;
  // Software can also take the target off the bus
  assign active = pg_s && cur_reg.link_en;
  assign apb_setup = PSEL_IN && !PENABLE_IN;
  assign apb_access = PSEL_IN && PENABLE_IN;
  assign wr_sel = cur_reg.shift[`LNBI2C_SEL_MSB:`LNBI2C_SEL_LSB];

  // Read image: index 0 is status with live flags
  function automatic logic [7:0] rd_byte(input logic [1:0] idx,
                                         input logic [3:0][7:0] regs,
                                         input logic [`LNBI2C_FAULT_W-1:0] flt);
    if (idx == 2'h0) begin
      rd_byte = {`LNBI2C_SEL_STATUS, flt};
    end else begin
      rd_byte = regs[idx];
    end
  endfunction : rd_byte

  // Unmapped offsets answer with an error
  always_comb begin
    case (PADDR_IN[7:0])
      `LNBI2C_OFS_STATUS, `LNBI2C_OFS_TONE, `LNBI2C_OFS_CMD,
      `LNBI2C_OFS_OUTCTRL, `LNBI2C_OFS_CTRL, `LNBI2C_OFS_LINKSTAT,
      `LNBI2C_OFS_XFERCNT: apb_mapped = (PADDR_IN >> 8) == '0;
      default: apb_mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    cur_next = cur_reg;
    cur_next.scl_d = scl_s;
    cur_next.sda_d = sda_s;
    // APB read data captured in setup, shown in access
    if (apb_setup) begin
      case (PADDR_IN[7:0])
        `LNBI2C_OFS_STATUS: cur_next.rdata = {24'h0, rd_byte(2'h0, cur_reg.sysreg,
                                                            FAULT_FLAGS_IN)};
        `LNBI2C_OFS_TONE: cur_next.rdata = {24'h0, cur_reg.sysreg[1]};
        `LNBI2C_OFS_CMD: cur_next.rdata = {24'h0, cur_reg.sysreg[2]};
        `LNBI2C_OFS_OUTCTRL: cur_next.rdata = {24'h0, cur_reg.sysreg[3]};
        `LNBI2C_OFS_CTRL: cur_next.rdata = {31'h0, cur_reg.link_en};
        `LNBI2C_OFS_LINKSTAT: cur_next.rdata = {20'h0, cur_reg.st, cur_reg.sda_oe,
                                                 pg_s, own_addr};
        `LNBI2C_OFS_XFERCNT: cur_next.rdata = {16'h0, cur_reg.xfer_cnt};
        default: cur_next.rdata = 32'h0;
      endcase
    end
    // Control write takes effect at the access edge
    if (apb_access && PWRITE_IN && PADDR_IN == APB_AW'(`LNBI2C_OFS_CTRL)) begin
      cur_next.link_en = PWDATA_IN[`LNBI2C_CTRL_LINK_EN_BIT];
    end
    // Two-wire sequencer
    if (!active) begin
      cur_next.st = ST_IDLE;
      cur_next.sda_oe = 1'b0;
      cur_next.cnt = 4'h0;
    end else if (start_cond) begin
      cur_next.st = ST_ADDR;
      cur_next.cnt = 4'h0;
      cur_next.sda_oe = 1'b0;
    end else if (stop_cond) begin
      cur_next.st = ST_IDLE;
      cur_next.sda_oe = 1'b0;
    end else begin
      case (cur_reg.st)
        ST_ADDR: begin
          if (scl_rise) begin
            cur_next.shift = {cur_reg.shift[6:0], sda_s};
            cur_next.cnt = cur_reg.cnt + 4'h1;
          end else if (scl_fall && cur_reg.cnt == `LNBI2C_BITS_PER_BYTE) begin
            // Foreign addresses leave the line alone until the next start
            if (cur_reg.shift[7:1] == own_addr) begin
              cur_next.st = ST_ADDR_ACK;
              cur_next.rw = cur_reg.shift[0];
              cur_next.sda_oe = 1'b1;
              cur_next.xfer_cnt = cur_reg.xfer_cnt + 16'h1;
            end else begin
              cur_next.st = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            cur_next.cnt = 4'h0;
            if (cur_reg.rw) begin
              cur_next.ptr = 2'h0;
              cur_next.shift = rd_byte(2'h0, cur_reg.sysreg, FAULT_FLAGS_IN);
              cur_next.sda_oe = !cur_next.shift[7];
              cur_next.st = ST_RD;
            end else begin
              cur_next.sda_oe = 1'b0;
              cur_next.st = ST_WR;
            end
          end
        end
        ST_WR: begin
          if (scl_rise) begin
            cur_next.shift = {cur_reg.shift[6:0], sda_s};
            cur_next.cnt = cur_reg.cnt + 4'h1;
          end else if (scl_fall && cur_reg.cnt == `LNBI2C_BITS_PER_BYTE) begin
            // Status selector and undefined selectors store nothing
            if (wr_sel != `LNBI2C_SEL_STATUS && wr_sel <= `LNBI2C_SEL_LAST) begin
              cur_next.sysreg[wr_sel[1:0]] = cur_reg.shift;
            end
            cur_next.sda_oe = 1'b1;
            cur_next.st = ST_WR_ACK;
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            cur_next.sda_oe = 1'b0;
            cur_next.cnt = 4'h0;
            cur_next.st = ST_WR;
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (cur_reg.cnt == `LNBI2C_LAST_RD_BIT) begin
              cur_next.sda_oe = 1'b0;
              cur_next.st = ST_RD_ACK;
            end else begin
              cur_next.shift = {cur_reg.shift[6:0], 1'b0};
              cur_next.cnt = cur_reg.cnt + 4'h1;
              cur_next.sda_oe = !cur_reg.shift[6];
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            cur_next.cont = !sda_s;
            if (!sda_s) begin
              cur_next.ptr = cur_reg.ptr + 2'h1;
            end
          end else if (scl_fall) begin
            if (cur_reg.cont) begin
              cur_next.shift = rd_byte(cur_reg.ptr, cur_reg.sysreg, FAULT_FLAGS_IN);
              cur_next.sda_oe = !cur_next.shift[7];
              cur_next.cnt = 4'h0;
              cur_next.st = ST_RD;
            end else begin
              cur_next.sda_oe = 1'b0;
              cur_next.st = ST_IDLE;
            end
          end
        end
        default: begin
          cur_next.st = ST_IDLE;
          cur_next.sda_oe = 1'b0;
        end
      endcase
    end
    // Supply loss wipes the configuration; keeps power stages off
    if (!pg_s) begin
      cur_next.sysreg = {4{`LNBI2C_SYSREG_RESET}};
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      cur_reg <= '0;
      cur_reg.st <= ST_IDLE;
      cur_reg.scl_d <= 1'b1;
      cur_reg.sda_d <= 1'b1;
      cur_reg.link_en <= `LNBI2C_CTRL_RESET;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Open drain: only ever pulls low
  assign SDA_OUT = 1'b0;
  assign SDA_OE_OUT = cur_reg.sda_oe;
  assign TONE_CFG_OUT = cur_reg.sysreg[1];
  assign COMMAND_CFG_OUT = cur_reg.sysreg[2];
  assign OUTPUT_CTRL_OUT = cur_reg.sysreg[3];
  // Zero wait states; data already captured in setup
  assign PREADY_OUT = 1'b1;
  assign PRDATA_OUT = cur_reg.rdata;
  assign PSLVERR_OUT = apb_access && !apb_mapped;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!rst_n);

  AST_PG_LOW_SILENT: assert property (
    !pg_s |=> !cur_reg.sda_oe && cur_reg.st == ST_IDLE)
    else $error("data line driven while supply not good");

  AST_PG_LOW_REGS_ZERO: assert property (
    !pg_s |=> cur_reg.sysreg == '0 && OUTPUT_CTRL_OUT == 8'h00)
    else $error("system registers not cleared while supply not good");

  AST_ACK_OWN_ONLY: assert property (
    cur_reg.st == ST_ADDR && cur_next.st == ST_ADDR_ACK
    |-> cur_reg.shift[7:1] == {`LNBI2C_ADDR_UPPER, sel_hi_s, sel_lo_s})
    else $error("acknowledge given to a foreign address");

  AST_STRAP_ADDR: assert property (
    cur_reg.st == ST_ADDR && scl_fall && cur_reg.cnt == 4'h8 && pg_s
    && !start_cond && !stop_cond && cur_reg.link_en
    && cur_reg.shift[7:1] == 7'h08 && !sel_hi_s && !sel_lo_s
    |=> cur_reg.st == ST_ADDR_ACK && cur_reg.sda_oe)
    else $error("base address not acknowledged with straps low");

  AST_RD_MSB_FIRST: assert property (
    cur_reg.st == ST_RD && active && !start_cond && !stop_cond
    && scl_fall && cur_reg.cnt < 4'h7
    |=> cur_reg.shift == {$past(cur_reg.shift[6:0]), 1'b0}
    && cur_reg.sda_oe == !cur_reg.shift[7])
    else $error("read byte not shifted out most significant bit first");

  AST_RD_STATUS_FIRST: assert property (
    cur_reg.st == ST_ADDR_ACK && cur_next.st == ST_RD
    |=> cur_reg.ptr == 2'h0 && cur_reg.shift == {3'h0, $past(FAULT_FLAGS_IN)})
    else $error("read did not start with status and live flags");

  AST_ACK_NEXT_REG: assert property (
    cur_reg.st == ST_RD_ACK && active && scl_rise && !sda_s
    && !start_cond && !stop_cond
    |=> cur_reg.cont && cur_reg.ptr == $past(cur_reg.ptr) + 2'h1)
    else $error("acknowledge did not advance the read index");

  AST_ACK_CONTINUES: assert property (
    cur_reg.st == ST_RD_ACK && cur_reg.cont && scl_fall && active
    && !start_cond && !stop_cond
    |=> cur_reg.st == ST_RD && cur_reg.cnt == 4'h0)
    else $error("acknowledged read did not continue");

  AST_NACK_RELEASE: assert property (
    cur_reg.st == ST_RD_ACK && !cur_reg.cont && scl_fall
    |=> cur_reg.st == ST_IDLE && !cur_reg.sda_oe)
    else $error("read not ended on missing acknowledge");

  AST_WRITE_SELECT: assert property (
    cur_reg.st == ST_WR && cur_next.st == ST_WR_ACK && pg_s && wr_sel == 3'h3
    |=> OUTPUT_CTRL_OUT == $past(cur_reg.shift) && cur_reg.sda_oe)
    else $error("control register write lost");

  COV_READ_TWO: cover property (cur_reg.st == ST_RD_ACK && cur_reg.cont
    ##[1:100] cur_reg.st == ST_RD);
  COV_WRITE: cover property (cur_reg.st == ST_WR_ACK && pg_s);
  COV_NACK: cover property (cur_reg.st == ST_RD_ACK ##1 cur_reg.st == ST_IDLE);
  COV_FOREIGN: cover property (cur_reg.st == ST_ADDR ##1 cur_reg.st == ST_IDLE);

endmodule : lnbi2c_top

`default_nettype wire

// file: lnbi2c_host_model.sv
// Behavioural two-wire bus controller standing in for the host microcontroller
`default_nettype none

module lnbi2c_host_model (
  // Bench clock that paces the serial clock
  input wire logic clk_in,
  // Resolved data line
  input wire logic sda_in,
  // Serial clock and data pull-down
  output logic scl_out,
  output logic sda_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------------
  // Idle bus: clock high, data released to the pull-up
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end

  // Wait a number of bench clocks
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick

  // Low 5 clocks, high 3: 800 ns per bit; data moves 3 clocks after the fall
  task automatic put_bit(input logic b, output logic got);
    tick(3);
    sda_oe_out <= ~b;
    tick(2);
    scl_out <= 1'b1;
    tick(2);
    got = sda_in;
    tick(1);
    scl_out <= 1'b0;
  endtask : put_bit

  // Start or repeated start: data falls while the clock is high
  task automatic start();
    tick(3);
    sda_oe_out <= 1'b0;
    tick(2);
    scl_out <= 1'b1;
    tick(3);
    sda_oe_out <= 1'b1;
    tick(3);
    scl_out <= 1'b0;
  endtask : start

  // Stop: data rises while the clock is high, then the bus idles
  task automatic stop();
    tick(3);
    sda_oe_out <= 1'b1;
    tick(2);
    scl_out <= 1'b1;
    tick(3);
    sda_oe_out <= 1'b0;
    tick(4);
  endtask : stop

  // Byte out, MSB first; ack is the target's pull-down on the ninth clock
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], g);
    end
    put_bit(1'b1, g);
    ack = ~g;
  endtask : send_byte

  // Byte in; ninth clock acks to go on or leaves the line high to end
  task automatic recv_byte(input logic ack_it, output logic [7:0] b);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, b[i]);
    end
    put_bit(~ack_it, g);
  endtask : recv_byte

endmodule : lnbi2c_host_model

`default_nettype wire

// file: lnbi2c_top_tb.sv
// Self-checking bench for the supply-controller two-wire target
`include "lnbi2c_defines.svh"
`default_nettype none

module lnbi2c_top_tb;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] strap;
    logic [7:0] addr;
    logic [7:0] data;
    logic ack;
  } lnbi2c_row_t;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pg = 1'b0;
  logic asl = 1'b0;
  logic ash = 1'b0;
  logic [4:0] flt = 5'h00;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic sda_val, sda_oe, scl, host_oe, sda_bus, pready, pslverr;
  logic [7:0] tone, cmd, ctrl;
  logic [31:0] prdata;
  int fail_count = 0;
  int comparisons = 0;

  // Writes by strap, then foreign addresses; tone written last
  lnbi2c_row_t rows [6] = '{
    '{2'h0, 8'h10, 8'h2c, 1'b1}, '{2'h1, 8'h12, 8'h47, 1'b1},
    '{2'h2, 8'h14, 8'h6a, 1'b1}, '{2'h3, 8'h16, 8'h34, 1'b1},
    '{2'h0, 8'h12, 8'h3f, 1'b0}, '{2'h3, 8'h10, 8'h3f, 1'b0}};
  logic [7:0] exp_rd [5] = '{8'h15, 8'h34, 8'h47, 8'h6a, 8'h0a};

  always #50 clk = ~clk;

  // Open-drain wire with pull-up
  assign sda_bus = (sda_oe ? sda_val : 1'b1) & ~host_oe;

  lnbi2c_top #(.APB_AW(8)) i_dut (
    .CLK_IN(clk), .RESETN_IN(rst_n), .SUPPLY_GOOD_IN(pg),
    .ADDR_SEL_LOW_IN(asl), .ADDR_SEL_HIGH_IN(ash), .FAULT_FLAGS_IN(flt),
    .SCL_IN(scl), .SDA_IN(sda_bus), .SDA_OUT(sda_val), .SDA_OE_OUT(sda_oe),
    .TONE_CFG_OUT(tone), .COMMAND_CFG_OUT(cmd), .OUTPUT_CTRL_OUT(ctrl),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr));

  lnbi2c_host_model i_host (
    .clk_in(clk), .sda_in(sda_bus), .scl_out(scl), .sda_oe_out(host_oe));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    // No wait count assumed; only the watchdog ends a hung access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  // Address phase alone, answer returned
  task automatic probe(input logic [7:0] a, output logic ack);
    i_host.start();
    i_host.send_byte(a, ack);
    i_host.stop();
  endtask : probe

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic ack;
    logic dummy;
    logic err;
    logic [7:0] b;
    logic [31:0] d;
    tick(3);
    rst_n <= 1'b1;
    tick(4);
    check({sda_oe, tone, cmd, ctrl}, 32'h0);
    // Supply still low: the bus is ignored
    probe(8'h11, ack);
    check(ack, 1'b0);
    pg <= 1'b1;
    tick(6);
    foreach (rows[i]) begin
      {ash, asl} <= rows[i].strap;
      tick(4);
      i_host.start();
      i_host.send_byte(rows[i].addr, ack);
      if (ack === 1'b1) i_host.send_byte(rows[i].data, dummy);
      i_host.stop();
      check(ack, rows[i].ack);
    end
    check({tone, cmd, ctrl}, {8'h34, 8'h47, 8'h6a});
    // Five-byte read wraps back to status; flags change mid-read
    {ash, asl} <= 2'h0;
    flt <= 5'h15;
    tick(4);
    i_host.start();
    i_host.send_byte(8'h11, ack);
    check(ack, 1'b1);
    foreach (exp_rd[i]) begin
      i_host.recv_byte(i < 4, b);
      if (i == 0) flt <= 5'h0a;
      check(b, exp_rd[i]);
    end
    tick(4);
    check(sda_oe, 1'b0);
    i_host.stop();
    // Register bus: copy, unmapped offset, link disable
    apb(1'b0, `LNBI2C_OFS_TONE, 32'h0, d, err);
    check(d, 32'h34);
    check(err, 1'b0);
    apb(1'b0, 8'h1c, 32'h0, d, err);
    check(d, 32'h0);
    check(err, 1'b1);
    // Status image with live flags, acked address count, link state
    apb(1'b0, `LNBI2C_OFS_STATUS, 32'h0, d, err);
    check(d, 32'h0a);
    apb(1'b0, `LNBI2C_OFS_XFERCNT, 32'h0, d, err);
    check(d, 32'h5);
    apb(1'b0, `LNBI2C_OFS_LINKSTAT, 32'h0, d, err);
    check(d, 32'h88);
    apb(1'b1, `LNBI2C_OFS_CTRL, 32'h0, d, err);
    probe(8'h11, ack);
    check(ack, 1'b0);
    apb(1'b1, `LNBI2C_OFS_CTRL, 32'h1, d, err);
    // Supply drop clears the system registers
    pg <= 1'b0;
    tick(4);
    check({tone, cmd, ctrl}, 24'h0);
    pg <= 1'b1;
    tick(6);
    // Output enable goes in the second data byte, after the command byte
    i_host.start();
    i_host.send_byte(8'h10, ack);
    i_host.send_byte(8'h47, dummy);
    i_host.send_byte(8'h71, dummy);
    // Status and undefined selectors must store nothing
    i_host.send_byte(8'h1f, dummy);
    i_host.send_byte(8'h9f, dummy);
    i_host.stop();
    check({ack, tone, cmd, ctrl}, {1'b1, 8'h00, 8'h47, 8'h71});
    print_verdict();
  end

  // Hang guard well beyond the expected run length
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    print_verdict();
  end

endmodule : lnbi2c_top_tb

`default_nettype wire
